// ### hw/hsi_map.svh
// Bit positions, codes and limits of the isochronous descriptor fields.
`ifndef HSI_MAP_SVH
`define HSI_MAP_SVH
// Upper quad word (fourth word : third word).
`define HSI_ACTIVE_BIT   63
`define HSI_HALT_BIT     62
`define HSI_BABBLE_BIT   61
`define HSI_CNT_HI       46
`define HSI_CNT_LO       32
`define HSI_PTR_HI       23
`define HSI_PTR_LO       8
`define HSI_FRM_HI       7
`define HSI_FRM_LO       3
// Lower quad word (second word : first word).
`define HSI_SPLIT_BIT    46
`define HSI_KIND_HI      45
`define HSI_KIND_LO      44
`define HSI_TOK_HI       43
`define HSI_TOK_LO       42
`define HSI_ADDR_HI      41
`define HSI_ADDR_LO      35
`define HSI_EPH_HI       34
`define HSI_EPH_LO       32
`define HSI_EP0_BIT      31
`define HSI_VALID_BIT    0
// Codes and limits.
`define HSI_KIND_ISO     2'h1
`define HSI_TOK_OUT      2'h0
`define HSI_TOK_IN       2'h1
`define HSI_CNT_MAX      15'h7fff
`endif

// ### hw/hsi_pkg.sv
// Types shared by the isochronous descriptor logic.
`default_nettype none
package hsi_pkg;
    typedef enum logic [4:0] {
        ST_IDLE  = 5'b0_0001,
        ST_ARMED = 5'b0_0010,
        ST_ISSUE = 5'b0_0100,
        ST_WAIT  = 5'b0_1000,
        ST_WRITE = 5'b1_0000
    } hsi_state_e;
endpackage
`default_nettype wire

// ### hw/hsi_desc.sv
// Isochronous descriptor field engine: token issue, result capture, write-back.
`timescale 1ns/1ps
`default_nettype none
`include "hsi_map.svh"

module hsi_desc #(
    parameter int WB_W = 41
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        desc_load,
    input  wire logic [63:0] desc_q0,
    input  wire logic [63:0] desc_q1,
    input  wire logic [7:0]  desc_mask,
    input  wire logic        sof_pulse,
    input  wire logic [4:0]  bus_frame,
    input  wire logic [2:0]  bus_uframe,
    output logic             tok_valid,
    input  wire logic        tok_ready,
    output logic             tok_is_in,
    output logic             tok_split,
    output logic [6:0]       tok_addr,
    output logic [3:0]       tok_endp,
    output logic [15:0]      tok_ptr,
    input  wire logic        res_valid,
    output logic             res_ready,
    input  wire logic        res_stall,
    input  wire logic        res_fatal,
    input  wire logic        res_more,
    input  wire logic [10:0] res_bytes,
    output logic             wb_valid,
    input  wire logic        wb_ready,
    output logic [WB_W-1:0]  wb_word,
    output logic             desc_busy,
    output logic             halt_flag
);

    // =========================================================
    // Helpers
    function automatic logic [14:0] sat_add(input logic [14:0] a, input logic [10:0] b);
        logic [15:0] s;
        s = {1'b0, a} + {5'h0_0, b};
        sat_add = s[15] ? `HSI_CNT_MAX : s[14:0];
    endfunction

    // Mask bits strictly above the given microframe.
    function automatic logic [7:0] later_bits(input logic [7:0] m, input logic [2:0] u);
        later_bits = m & ~((8'h02 << u) - 8'h01);
    endfunction

    // =========================================================
    // Descriptor state
    hsi_pkg::hsi_state_e state_reg, state_next;
    logic        live_reg, live_next;
    logic        halt_reg, halt_next;
    logic [14:0] cnt_reg, cnt_next;
    logic [7:0]  mask_reg, mask_next;
    logic [2:0]  uf_reg, uf_next;
    logic [4:0]  frm_reg, frm_next;
    logic [1:0]  kind_reg, kind_next;
    logic [1:0]  tcode_reg, tcode_next;
    logic        done_reg, done_next;
    logic        tv_reg, tv_next;
    logic        tin_reg, tin_next;
    logic        tsp_reg, tsp_next;
    logic [6:0]  tad_reg, tad_next;
    logic [3:0]  tep_reg, tep_next;
    logic [15:0] tpt_reg, tpt_next;
    logic        rr_reg, rr_next;
    logic        push;
    logic [WB_W-1:0] push_word;
    logic        buf_ready;
    logic        fire;

    // Issue only for a live isochronous descriptor with a known token in the
    // matching frame and an enabled microframe.
    always_comb begin
        fire = sof_pulse && live_reg && (kind_reg == `HSI_KIND_ISO)
            && (tcode_reg == `HSI_TOK_OUT || tcode_reg == `HSI_TOK_IN)
            && (bus_frame == frm_reg)
            && mask_reg[bus_uframe];
    end

    always_comb begin
        state_next = state_reg;
        live_next  = live_reg;
        halt_next  = halt_reg;
        cnt_next   = cnt_reg;
        mask_next  = mask_reg;
        uf_next    = uf_reg;
        frm_next   = frm_reg;
        kind_next  = kind_reg;
        tcode_next = tcode_reg;
        done_next  = done_reg;
        tv_next    = tv_reg;
        tin_next   = tin_reg;
        tsp_next   = tsp_reg;
        tad_next   = tad_reg;
        tep_next   = tep_reg;
        tpt_next   = tpt_reg;
        rr_next    = 1'b0;
        push       = 1'b0;
        case (state_reg)
            hsi_pkg::ST_IDLE, hsi_pkg::ST_ARMED: begin
                if (desc_load) begin
                    // Valid and active must both be set for a live descriptor.
                    live_next  = desc_q0[`HSI_VALID_BIT] && desc_q1[`HSI_ACTIVE_BIT];
                    halt_next  = 1'b0;
                    cnt_next   = 15'h0000;
                    mask_next  = desc_mask;
                    frm_next   = desc_q1[`HSI_FRM_HI:`HSI_FRM_LO];
                    kind_next  = desc_q0[`HSI_KIND_HI:`HSI_KIND_LO];
                    tcode_next = desc_q0[`HSI_TOK_HI:`HSI_TOK_LO];
                    tin_next   = desc_q0[`HSI_TOK_HI:`HSI_TOK_LO] == `HSI_TOK_IN;
                    tsp_next   = desc_q0[`HSI_SPLIT_BIT];
                    tad_next   = desc_q0[`HSI_ADDR_HI:`HSI_ADDR_LO];
                    tep_next   = {desc_q0[`HSI_EPH_HI:`HSI_EPH_LO],
                                  desc_q0[`HSI_EP0_BIT]};
                    tpt_next   = desc_q1[`HSI_PTR_HI:`HSI_PTR_LO];
                    state_next = hsi_pkg::ST_ARMED;
                end else if (state_reg == hsi_pkg::ST_ARMED && !live_reg) begin
                    state_next = hsi_pkg::ST_IDLE;
                end else if (state_reg == hsi_pkg::ST_ARMED && fire) begin
                    uf_next    = bus_uframe;
                    cnt_next   = 15'h0000;
                    tv_next    = 1'b1;
                    state_next = hsi_pkg::ST_ISSUE;
                end
            end
            hsi_pkg::ST_ISSUE: begin
                if (tok_ready) begin
                    tv_next    = 1'b0;
                    rr_next    = 1'b1;
                    state_next = hsi_pkg::ST_WAIT;
                end
            end
            hsi_pkg::ST_WAIT: begin
                rr_next = 1'b1;
                if (res_valid) begin
                    rr_next  = 1'b0;
                    cnt_next = sat_add(cnt_reg, res_bytes);
                    if (res_stall) begin
                        halt_next = 1'b1;
                        live_next = 1'b0;
                        done_next = 1'b1;
                        mask_next = mask_reg & ~(8'h01 << uf_reg);
                        state_next = hsi_pkg::ST_WRITE;
                    end else if (res_fatal) begin
                        live_next  = 1'b0;
                        done_next  = 1'b1;
                        mask_next  = mask_reg & ~(8'h01 << uf_reg);
                        state_next = hsi_pkg::ST_WRITE;
                    end else if (res_more) begin
                        rr_next = 1'b1;
                    end else begin
                        mask_next = mask_reg & ~(8'h01 << uf_reg);
                        done_next = later_bits(mask_reg, uf_reg) == 8'h00;
                        live_next = later_bits(mask_reg, uf_reg) != 8'h00;
                        state_next = hsi_pkg::ST_WRITE;
                    end
                end
            end
            hsi_pkg::ST_WRITE: begin
                if (buf_ready) begin
                    push       = 1'b1;
                    state_next = done_reg ? hsi_pkg::ST_IDLE : hsi_pkg::ST_ARMED;
                    done_next  = 1'b0;
                end
            end
            default: begin
                state_next = hsi_pkg::ST_IDLE;
                live_next  = 1'b0;
                tv_next    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= hsi_pkg::ST_IDLE;
            live_reg  <= 1'b0;
            halt_reg  <= 1'b0;
            cnt_reg   <= 15'h0000;
            mask_reg  <= 8'h00;
            uf_reg    <= 3'h0;
            frm_reg   <= 5'h00;
            kind_reg  <= 2'h0;
            tcode_reg <= 2'h0;
            done_reg  <= 1'b0;
            tv_reg    <= 1'b0;
            tin_reg   <= 1'b0;
            tsp_reg   <= 1'b0;
            tad_reg   <= 7'h00;
            tep_reg   <= 4'h0;
            tpt_reg   <= 16'h0000;
            rr_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            live_reg  <= live_next;
            halt_reg  <= halt_next;
            cnt_reg   <= cnt_next;
            mask_reg  <= mask_next;
            uf_reg    <= uf_next;
            frm_reg   <= frm_next;
            kind_reg  <= kind_next;
            tcode_reg <= tcode_next;
            done_reg  <= done_next;
            tv_reg    <= tv_next;
            tin_reg   <= tin_next;
            tsp_reg   <= tsp_next;
            tad_reg   <= tad_next;
            tep_reg   <= tep_next;
            tpt_reg   <= tpt_next;
            rr_reg    <= rr_next;
        end
    end

    // Write-back word: mask, valid, then the whole fourth word.
    // Valid and active go out as the same live bit; babble and reserved stay zero.
    always_comb begin
        push_word = {mask_reg, live_reg, live_reg, halt_reg, 1'b0, 14'h0000, cnt_reg};
    end

    // =========================================================
    // Two-entry write-back buffer
    // An output stage plus a skid stage; ready toward the engine is a flop,
    // so a memory stall costs no word and never loops combinationally.
    logic            ov_reg, ov_next;
    logic [WB_W-1:0] od_reg, od_next;
    logic            sv_reg, sv_next;
    logic [WB_W-1:0] sd_reg, sd_next;

    always_comb begin
        buf_ready = !sv_reg;
        ov_next = ov_reg;
        od_next = od_reg;
        sv_next = sv_reg;
        sd_next = sd_reg;
        if (!ov_reg || wb_ready) begin
            if (sv_reg) begin
                ov_next = 1'b1;
                od_next = sd_reg;
                sv_next = 1'b0;
            end else begin
                ov_next = push;
                od_next = push ? push_word : od_reg;
            end
        end else if (push) begin
            sv_next = 1'b1;
            sd_next = push_word;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ov_reg <= 1'b0;
            od_reg <= '0;
            sv_reg <= 1'b0;
            sd_reg <= '0;
        end else begin
            ov_reg <= ov_next;
            od_reg <= od_next;
            sv_reg <= sv_next;
            sd_reg <= sd_next;
        end
    end

    // =========================================================
    // Outputs
    always_comb begin
        tok_valid = tv_reg;
        tok_is_in = tin_reg;
        tok_split = tsp_reg;
        tok_addr  = tad_reg;
        tok_endp  = tep_reg;
        tok_ptr   = tpt_reg;
        res_ready = rr_reg;
        wb_valid  = ov_reg;
        wb_word   = od_reg;
        desc_busy = live_reg;
        halt_flag = halt_reg;
    end

    // =========================================================
    // Checks
    a_halt_kills_valid: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(halt_reg) |-> !live_reg) else $error("halt set while valid stays set");
    a_stall_sets_halt: assert property (@(posedge clk_sys) disable iff (rst)
        state_reg == hsi_pkg::ST_WAIT && res_valid && res_stall |=> halt_reg)
        else $error("stall did not set halt");
    a_babble_zero: assert property (@(posedge clk_sys) disable iff (rst)
        wb_valid |-> !wb_word[29]) else $error("babble reported for iso");
    a_count_sum: assert property (@(posedge clk_sys) disable iff (rst)
        state_reg == hsi_pkg::ST_WAIT && res_valid && cnt_reg == 15'h0000
        |=> cnt_reg == {4'h0, $past(res_bytes)}) else $error("byte count wrong");
    a_more_keeps: assert property (@(posedge clk_sys) disable iff (rst)
        state_reg == hsi_pkg::ST_WAIT && res_valid && res_more && !res_stall && !res_fatal
        |=> state_reg == hsi_pkg::ST_WAIT && cnt_reg >= $past(cnt_reg))
        else $error("running total lost");
    a_token_fields: assert property (@(posedge clk_sys) disable iff (rst)
        state_reg != hsi_pkg::ST_WRITE && desc_load && state_reg != hsi_pkg::ST_ISSUE
        && state_reg != hsi_pkg::ST_WAIT
        |=> tok_addr == $past(desc_q0[41:35]) && tok_endp == {$past(desc_q0[34:32]),
        $past(desc_q0[31])} && tok_split == $past(desc_q0[46]))
        else $error("token fields not taken from descriptor");
    a_fire_gated: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(tok_valid) |-> $past(mask_reg[bus_uframe]) && $past(bus_frame) == $past(frm_reg))
        else $error("token outside enabled microframe");
    a_dead_no_token: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(tok_valid) |-> $past(live_reg)) else $error("token for dead descriptor");
    a_fatal_clears: assert property (@(posedge clk_sys) disable iff (rst)
        state_reg == hsi_pkg::ST_WAIT && res_valid && res_fatal |=> !live_reg)
        else $error("fatal error left valid set");
    a_token_done: assert property (@(posedge clk_sys) disable iff (rst)
        tok_valid && tok_ready |=> !tok_valid ##0 res_ready) else $error("token handshake");

endmodule
`default_nettype wire

// ### test/hsi_usb_func.sv
// Behavioural model of the USB function on the far side of the token and result ports.
`timescale 1ns/1ps
`default_nettype none
module hsi_usb_func (
    input  wire logic        clk_sys,
    input  wire logic        tok_valid,
    output logic             tok_ready,
    input  wire logic        res_ready,
    output logic             res_valid,
    output logic             res_stall,
    output logic             res_fatal,
    output logic             res_more,
    output logic [10:0]      res_bytes,
    input  wire logic [4:0]  cfg_pkts,
    input  wire logic [10:0] cfg_bytes,
    input  wire logic [1:0]  cfg_end,
    input  wire logic [1:0]  cfg_slow
);
    logic [4:0]  pkts;
    logic [10:0] bytes;
    logic [1:0]  fin;
    logic [1:0]  slow;

    initial begin
        tok_ready = 1'h0;
        res_valid = 1'h0;
        {res_stall, res_fatal, res_more, res_bytes} = 14'h0000;
    end

    // Settings are taken at the edge so that the bench may change them just after it.
    always begin
        @(posedge clk_sys);
        {pkts, bytes, fin, slow} = {cfg_pkts, cfg_bytes, cfg_end, cfg_slow};
        #1;
        if (tok_valid === 1'h1) begin
            repeat (slow) begin
                @(posedge clk_sys);
                #1;
            end
            tok_ready = 1'h1;
            @(posedge clk_sys);
            #1;
            tok_ready = 1'h0;
            for (int i = 1; i <= pkts; i++) begin
                // Bounded: a design that never asks is caught by the bench's own timeout.
                for (int n = 0; n < 80 && res_ready !== 1'h1; n++) begin
                    @(posedge clk_sys);
                    #1;
                end
                res_valid = 1'h1;
                res_more = (i < pkts);
                res_stall = (i == pkts) && (fin == 2'h1);
                res_fatal = (i == pkts) && (fin == 2'h2);
                res_bytes = bytes;
                @(posedge clk_sys);
                #1;
                // Valid stays up between packets, so no signal is set twice in one step.
                // Once released, the qualifiers show garbage, never the last value.
                if (i == pkts) begin
                    res_valid = 1'h0;
                    {res_stall, res_fatal, res_more} = ~{res_stall, res_fatal, res_more};
                    res_bytes = ~res_bytes;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the isochronous descriptor engine.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_sys, rst, desc_load, sof_pulse, wb_ready, tok_valid, tok_ready, tok_is_in;
    logic        tok_split, res_valid, res_ready, res_stall, res_fatal, res_more, wb_valid;
    logic        desc_busy, halt_flag;
    logic [63:0] desc_q0, desc_q1;
    logic [7:0]  desc_mask;
    logic [4:0]  bus_frame, cfg_pkts;
    logic [2:0]  bus_uframe;
    logic [6:0]  tok_addr;
    logic [3:0]  tok_endp;
    logic [15:0] tok_ptr;
    logic [10:0] res_bytes, cfg_bytes;
    logic [40:0] wb_word;
    logic [1:0]  cfg_end, cfg_slow;
    int          miscompares, num_checks;

    hsi_desc dut_u (.clk_sys, .rst, .desc_load, .desc_q0, .desc_q1, .desc_mask, .sof_pulse,
        .bus_frame, .bus_uframe, .tok_valid, .tok_ready, .tok_is_in, .tok_split, .tok_addr,
        .tok_endp, .tok_ptr, .res_valid, .res_ready, .res_stall, .res_fatal, .res_more,
        .res_bytes, .wb_valid, .wb_ready, .wb_word, .desc_busy, .halt_flag);
    hsi_usb_func func_u (.clk_sys, .tok_valid, .tok_ready, .res_ready, .res_valid, .res_stall,
        .res_fatal, .res_more, .res_bytes, .cfg_pkts, .cfg_bytes, .cfg_end, .cfg_slow);

    initial begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // Access tasks
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic give_verdict();
        $display("checks %0d, miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic wait_for(input string what, ref logic sig, input logic lvl);
        int n;
        n = 0;
        while (sig !== lvl) begin
            step(1);
            n++;
            if (n > 80) begin
                miscompares++;
                $display("unexpected %s: expected %h, seen timeout", what, lvl);
                give_verdict();
            end
        end
    endtask
    function automatic logic [63:0] mk_q0(input logic sp, input logic [1:0] kind, tok,
                                          input logic [6:0] addr, input logic [3:0] ep);
        return {17'h0_0000, sp, kind, tok, addr, ep[3:1], ep[0], 30'h0000_0000, 1'h1};
    endfunction
    function automatic logic [63:0] mk_q1(input logic act, input logic [31:0] cpu,
                                          input logic [4:0] frm);
        logic [31:0] ram;
        ram = (cpu - 32'h0000_0400) >> 3;
        return {act, 2'h0, 14'h0000, 15'h0000, 8'h00, ram[15:0], frm, 3'h7};
    endfunction
    function automatic logic [40:0] wbw(input logic [7:0] m, input logic v, a, h,
                                        input logic [14:0] cnt);
        return {m, v, a, h, 1'h0, 14'h0000, cnt};
    endfunction
    task automatic load(input logic [63:0] q0, q1, input logic [7:0] m);
        desc_q0 = q0;
        desc_q1 = q1;
        desc_mask = m;
        desc_load = 1'h1;
        step(1);
        desc_load = 1'h0;
    endtask
    task automatic answer(input logic [4:0] p, input logic [10:0] b, input logic [1:0] e, s);
        {cfg_pkts, cfg_bytes, cfg_end, cfg_slow} = {p, b, e, s};
    endtask
    task automatic sof(input logic [4:0] f, input logic [2:0] u);
        sof_pulse = 1'h1;
        bus_frame = f;
        bus_uframe = u;
        step(1);
        sof_pulse = 1'h0;
    endtask
    task automatic quiet(input string what);
        logic seen;
        seen = tok_valid;
        repeat (6) begin
            step(1);
            seen = seen | tok_valid;
        end
        chk(what, 64'h0, {63'h0, seen});
    endtask
    task automatic run_tok(input logic [4:0] f, input logic [2:0] u, input logic [28:0] exp);
        sof(f, u);
        wait_for("token", tok_valid, 1'h1);
        chk("token", {35'h0, exp}, {35'h0, tok_is_in, tok_split, tok_addr, tok_endp, tok_ptr});
        wait_for("result wait", res_ready, 1'h1);
        wait_for("result end", res_ready, 1'h0);
        step(2);
    endtask
    task automatic take_wb(input logic [40:0] exp);
        wb_ready = 1'h1;
        wait_for("write-back", wb_valid, 1'h1);
        chk("write-back", {23'h0, exp}, {23'h0, wb_word});
        step(1);
        wb_ready = 1'h0;
        step(1);
    endtask

    // ==========================================================
    // Scenarios
    initial begin
        miscompares = 0;
        num_checks = 0;
        {rst, desc_load, sof_pulse, wb_ready, bus_frame, bus_uframe} = 12'h800;
        {desc_q0, desc_q1, desc_mask} = 136'h0;
        answer(5'h01, 11'h000, 2'h0, 2'h0);
        step(12);
        rst = 1'h0;
        chk("reset outputs", 64'h0,
            {59'h0, tok_valid, res_ready, wb_valid, desc_busy, halt_flag});
        load(mk_q0(1'h0, 2'h1, 2'h1, 7'h55, 4'hB), mk_q1(1'h1, 32'h0000_2400, 5'h0A), 8'h0D);
        sof(5'h0B, 3'h0);
        quiet("wrong frame");
        sof(5'h0A, 3'h1);
        quiet("masked microframe");
        answer(5'h03, 11'h064, 2'h0, 2'h2);
        run_tok(5'h0A, 3'h0, {2'h2, 7'h55, 4'hB, 16'h0400});
        chk("live", 64'h1, {63'h0, desc_busy});
        answer(5'h01, 11'h005, 2'h0, 2'h0);
        run_tok(5'h0A, 3'h2, {2'h2, 7'h55, 4'hB, 16'h0400});
        // Receiver stalled through both microframes: both words must still be there.
        take_wb(wbw(8'h0C, 1'h1, 1'h1, 1'h0, 15'h012C));
        take_wb(wbw(8'h08, 1'h1, 1'h1, 1'h0, 15'h0005));
        answer(5'h01, 11'h000, 2'h1, 2'h1);
        run_tok(5'h0A, 3'h3, {2'h2, 7'h55, 4'hB, 16'h0400});
        take_wb(wbw(8'h00, 1'h0, 1'h0, 1'h1, 15'h0000));
        chk("halted", 64'h2, {62'h0, halt_flag, desc_busy});
        answer(5'h01, 11'h040, 2'h2, 2'h0);
        load(mk_q0(1'h1, 2'h1, 2'h0, 7'h2A, 4'h6), mk_q1(1'h1, 32'h0000_7FF8, 5'h1F), 8'h80);
        run_tok(5'h1F, 3'h7, {2'h1, 7'h2A, 4'h6, 16'h0F7F});
        take_wb(wbw(8'h00, 1'h0, 1'h0, 1'h0, 15'h0040));
        answer(5'h11, 11'h7FF, 2'h0, 2'h1);
        load(mk_q0(1'h0, 2'h1, 2'h1, 7'h01, 4'h1), mk_q1(1'h1, 32'h0000_0400, 5'h00), 8'h01);
        run_tok(5'h00, 3'h0, {2'h2, 7'h01, 4'h1, 16'h0000});
        take_wb(wbw(8'h00, 1'h0, 1'h0, 1'h0, 15'h7FFF));
        load(mk_q0(1'h0, 2'h2, 2'h1, 7'h03, 4'h2), mk_q1(1'h1, 32'h0000_0800, 5'h04), 8'hFF);
        sof(5'h04, 3'h0);
        quiet("non-isochronous kind");
        load(mk_q0(1'h0, 2'h1, 2'h1, 7'h03, 4'h2), mk_q1(1'h0, 32'h0000_0800, 5'h04), 8'hFF);
        sof(5'h04, 3'h1);
        quiet("inactive descriptor");
        chk("inactive not live", 64'h0, {63'h0, desc_busy});
        load(mk_q0(1'h0, 2'h1, 2'h2, 7'h03, 4'h2), mk_q1(1'h1, 32'h0000_0800, 5'h04), 8'hFF);
        sof(5'h04, 3'h2);
        quiet("reserved token code");
        load(mk_q0(1'h0, 2'h1, 2'h1, 7'h03, 4'h2) ^ 64'h1, mk_q1(1'h1, 32'h0000_0800, 5'h04),
             8'hFF);
        sof(5'h04, 3'h3);
        quiet("invalid descriptor");
        chk("invalid not live", 64'h0, {63'h0, desc_busy});
        give_verdict();
    end
endmodule
`default_nettype wire
